// [design/ltl_lux_scale.sv]
`timescale 1ns/1ps
`default_nettype none
module ltl_lux_scale
   import ltl_pkg::*;
(
   input wire logic [LTL_EXP_W-1:0] exponent_i,
   input wire logic [LTL_MANT_W-1:0] mantissa_i,
   output logic [LTL_LUX_W-1:0] lux_o
);
   // Value in units of 0.01 lux: mantissa times two to the exponent
   always_comb begin
      lux_o = {{(LTL_LUX_W-LTL_MANT_W){1'b0}}, mantissa_i} << exponent_i;
   end
endmodule
`default_nettype wire

// [design/ltl_pkg.sv]
`default_nettype none
package ltl_pkg;
   // Register offsets
   localparam logic [7:0] LTL_OFS_LOW = 8'h02;
   localparam logic [7:0] LTL_OFS_HIGH = 8'h03;
   localparam logic [7:0] LTL_OFS_MAKER = 8'h7E;
   localparam logic [7:0] LTL_OFS_PART = 8'h7F;
   // Field layout of the limit and result words
   localparam int LTL_EXP_MSB = 15;
   localparam int LTL_EXP_LSB = 12;
   localparam int LTL_MANT_MSB = 11;
   localparam int LTL_MANT_LSB = 0;
   localparam int LTL_EXP_W = 4;
   localparam int LTL_MANT_W = 12;
   localparam int LTL_WORD_W = 16;
   // Common lux scale: mantissa shifted by up to 15 places, one LSB is 0.01 lux
   localparam int LTL_LUX_W = 27;
   // Reset values
   localparam logic [15:0] LTL_LOW_RESET = 16'h0000;
   localparam logic [15:0] LTL_HIGH_RESET = 16'hBFFF;
   localparam logic [15:0] LTL_UNMAPPED_READ = 16'h0000;
   // Range codes at or above this value are automatic; masking needs a lower one
   localparam logic [3:0] LTL_RANGE_AUTO_MIN = 4'hC;
   localparam logic [3:0] LTL_MASKED_EXP = 4'h0;
   // Fault counter: saturates at the largest consecutive count
   localparam int LTL_FAULT_W = 4;
   localparam logic [3:0] LTL_FAULT_MAX = 4'h8;
endpackage
`default_nettype wire

// [design/ltl_threshold_regs.sv]
// Overview of operation
// - Low threshold register at offset 02h is the lower comparison limit.
// - Low threshold: exponent bits 15:12, mantissa 11:0, read/write, reset zero.
// - Limit value in lux is 0.01 times two to exponent times mantissa.
// - Exponent zero gives 0.01 lux step; each step doubles, up to 1011b.
// - Result and both limits are compared on one common lux scale.
// - High threshold register at offset 03h is the upper comparison limit.
// - High threshold: exponent resets to Bh, mantissa resets to FFFh.
// - High comparison uses the true exponent, ignoring exponent masking.
// - Read-only maker code word at offset 7Eh, bits 15:0.
// - Read-only part code word at offset 7Fh.
// - Below-low flag sets after the selected count of consecutive low results.
// - With masking and manual range, readback result exponent shows 0000b.
`timescale 1ns/1ps
`default_nettype none
module ltl_threshold_regs
   import ltl_pkg::*;
#(
   parameter logic [15:0] MAKER_CODE = 16'hA5C3, // Arbitrary value
   parameter logic [15:0] PART_CODE = 16'h1D2E // Arbitrary value
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   input wire logic result_valid_i,
   input wire logic [15:0] result_word_i,
   input wire logic exponent_mask_enable_i,
   input wire logic [3:0] range_select_i,
   input wire logic [1:0] fault_count_select_i,
   output logic [15:0] result_readback_o,
   output logic above_high_flag_o,
   output logic below_low_flag_o
);
   logic [15:0] low_threshold_reg;
   logic [15:0] low_threshold_next;
   logic [15:0] high_threshold_reg;
   logic [15:0] high_threshold_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic [15:0] readback_reg;
   logic [15:0] readback_next;
   logic [LTL_FAULT_W-1:0] low_cnt_reg;
   logic [LTL_FAULT_W-1:0] low_cnt_next;
   logic [LTL_FAULT_W-1:0] high_cnt_reg;
   logic [LTL_FAULT_W-1:0] high_cnt_next;
   logic above_high_flag_reg;
   logic above_high_flag_next;
   logic below_low_flag_reg;
   logic below_low_flag_next;
   logic [LTL_LUX_W-1:0] result_lux;
   logic [LTL_LUX_W-1:0] low_lux;
   logic [LTL_LUX_W-1:0] high_lux;
   logic is_below;
   logic is_above;
   logic mask_active;

   // Consecutive measurements needed: 1, 2, 4 or 8
   function automatic logic [LTL_FAULT_W-1:0] fault_target(input logic [1:0] sel);
      fault_target = LTL_FAULT_W'(1) << sel;
   endfunction

   // Count of consecutive faults including the present one, saturating
   function automatic logic [LTL_FAULT_W-1:0] fault_step(input logic [LTL_FAULT_W-1:0] cnt);
      fault_step = (cnt >= LTL_FAULT_MAX) ? LTL_FAULT_MAX : cnt + LTL_FAULT_W'(1);
   endfunction

   // Result and limits brought to one scale, so differing exponents compare right
   ltl_lux_scale u_result_scale (
      .exponent_i(result_word_i[LTL_EXP_MSB:LTL_EXP_LSB]),
      .mantissa_i(result_word_i[LTL_MANT_MSB:LTL_MANT_LSB]),
      .lux_o(result_lux)
   );

   ltl_lux_scale u_low_scale (
      .exponent_i(low_threshold_reg[LTL_EXP_MSB:LTL_EXP_LSB]),
      .mantissa_i(low_threshold_reg[LTL_MANT_MSB:LTL_MANT_LSB]),
      .lux_o(low_lux)
   );

   ltl_lux_scale u_high_scale (
      .exponent_i(high_threshold_reg[LTL_EXP_MSB:LTL_EXP_LSB]),
      .mantissa_i(high_threshold_reg[LTL_MANT_MSB:LTL_MANT_LSB]),
      .lux_o(high_lux)
   );

   always_comb begin
      is_below = result_lux < low_lux;
      is_above = result_lux > high_lux;
      mask_active = exponent_mask_enable_i && (range_select_i < LTL_RANGE_AUTO_MIN);
   end

   // Register file: limits, read data
   always_comb begin
      low_threshold_next = low_threshold_reg;
      high_threshold_next = high_threshold_reg;
      rdata_next = rdata_reg;
      if (reg_wr_i) begin
         case (reg_addr_i)
            LTL_OFS_LOW: begin
               low_threshold_next = reg_wdata_i;
            end
            LTL_OFS_HIGH: begin
               high_threshold_next = reg_wdata_i;
            end
            default: begin
               // Code words and unmapped offsets take no write
               low_threshold_next = low_threshold_reg;
            end
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            LTL_OFS_LOW: begin
               rdata_next = low_threshold_reg;
            end
            LTL_OFS_HIGH: begin
               rdata_next = high_threshold_reg;
            end
            LTL_OFS_MAKER: begin
               rdata_next = MAKER_CODE;
            end
            LTL_OFS_PART: begin
               rdata_next = PART_CODE;
            end
            default: begin
               rdata_next = LTL_UNMAPPED_READ;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         low_threshold_reg <= LTL_LOW_RESET;
         high_threshold_reg <= LTL_HIGH_RESET;
         rdata_reg <= LTL_UNMAPPED_READ;
      end else begin
         low_threshold_reg <= low_threshold_next;
         high_threshold_reg <= high_threshold_next;
         rdata_reg <= rdata_next;
      end
   end

   // Comparison, fault counting and result readback, once per measurement
   always_comb begin
      low_cnt_next = low_cnt_reg;
      high_cnt_next = high_cnt_reg;
      below_low_flag_next = below_low_flag_reg;
      above_high_flag_next = above_high_flag_reg;
      readback_next = readback_reg;
      if (result_valid_i) begin
         if (is_below) begin
            low_cnt_next = fault_step(low_cnt_reg);
         end else begin
            low_cnt_next = '0;
         end
         if (is_above) begin
            high_cnt_next = fault_step(high_cnt_reg);
         end else begin
            high_cnt_next = '0;
         end
         below_low_flag_next = is_below &&
            (fault_step(low_cnt_reg) >= fault_target(fault_count_select_i));
         above_high_flag_next = is_above &&
            (fault_step(high_cnt_reg) >= fault_target(fault_count_select_i));
         readback_next = result_word_i;
         if (mask_active) begin
            readback_next[LTL_EXP_MSB:LTL_EXP_LSB] = LTL_MASKED_EXP;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         low_cnt_reg <= '0;
         high_cnt_reg <= '0;
         below_low_flag_reg <= 1'b0;
         above_high_flag_reg <= 1'b0;
         readback_reg <= '0;
      end else begin
         low_cnt_reg <= low_cnt_next;
         high_cnt_reg <= high_cnt_next;
         below_low_flag_reg <= below_low_flag_next;
         above_high_flag_reg <= above_high_flag_next;
         readback_reg <= readback_next;
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign result_readback_o = readback_reg;
   assign above_high_flag_o = above_high_flag_reg;
   assign below_low_flag_o = below_low_flag_reg;

   property p_low_write;
      @(posedge clk_i) disable iff (reset_i)
      (reg_wr_i && reg_addr_i == LTL_OFS_LOW) |=> low_threshold_reg == $past(reg_wdata_i);
   endproperty
   a_low_write: assert property (p_low_write) else $error("Low limit write lost");

   property p_high_write;
      @(posedge clk_i) disable iff (reset_i)
      (reg_wr_i && reg_addr_i == LTL_OFS_HIGH) |=> high_threshold_reg == $past(reg_wdata_i);
   endproperty
   a_high_write: assert property (p_high_write) else $error("High limit write lost");

   property p_limit_readback;
      @(posedge clk_i) disable iff (reset_i)
      (reg_rd_i && !reg_wr_i && reg_addr_i == LTL_OFS_HIGH) |=>
         reg_rdata_o == high_threshold_reg;
   endproperty
   a_limit_readback: assert property (p_limit_readback) else $error("High limit read wrong");

   property p_maker_read;
      @(posedge clk_i) disable iff (reset_i)
      (reg_rd_i && reg_addr_i == LTL_OFS_MAKER) |=> reg_rdata_o == MAKER_CODE;
   endproperty
   a_maker_read: assert property (p_maker_read) else $error("Maker code read wrong");

   property p_part_read;
      @(posedge clk_i) disable iff (reset_i)
      (reg_rd_i && reg_addr_i == LTL_OFS_PART) |=> reg_rdata_o == PART_CODE;
   endproperty
   a_part_read: assert property (p_part_read) else $error("Part code read wrong");

   property p_below_cause;
      @(posedge clk_i) disable iff (reset_i)
      $rose(below_low_flag_o) |-> $past(result_valid_i) && $past(is_below);
   endproperty
   a_below_cause: assert property (p_below_cause) else $error("Below flag without cause");

   property p_below_single;
      @(posedge clk_i) disable iff (reset_i)
      (result_valid_i && is_below && fault_count_select_i == 2'b00) |=> below_low_flag_o;
   endproperty
   a_below_single: assert property (p_below_single) else $error("Below flag not set");

   property p_above_clear;
      @(posedge clk_i) disable iff (reset_i)
      (result_valid_i && !is_above) |=> !above_high_flag_o;
   endproperty
   a_above_clear: assert property (p_above_clear) else $error("Above flag not cleared");

   property p_mask_exp;
      @(posedge clk_i) disable iff (reset_i)
      (result_valid_i && mask_active) |=>
         result_readback_o[LTL_EXP_MSB:LTL_EXP_LSB] == LTL_MASKED_EXP;
   endproperty
   a_mask_exp: assert property (p_mask_exp) else $error("Readback exponent not masked");

   property p_nomask_exp;
      @(posedge clk_i) disable iff (reset_i)
      (result_valid_i && !exponent_mask_enable_i) |=>
         result_readback_o == $past(result_word_i);
   endproperty
   a_nomask_exp: assert property (p_nomask_exp) else $error("Readback altered");

   property p_low_readback;
      @(posedge clk_i) disable iff (reset_i)
      (reg_rd_i && !reg_wr_i && reg_addr_i == LTL_OFS_LOW) |=>
         reg_rdata_o == low_threshold_reg;
   endproperty
   a_low_readback: assert property (p_low_readback) else $error("Low limit read wrong");

   property p_code_write_ignored;
      @(posedge clk_i) disable iff (reset_i)
      (reg_wr_i && reg_addr_i != LTL_OFS_LOW && reg_addr_i != LTL_OFS_HIGH) |=>
         $stable(low_threshold_reg) && $stable(high_threshold_reg);
   endproperty
   a_code_write_ignored: assert property (p_code_write_ignored) else $error("Limit changed");

   property p_above_single;
      @(posedge clk_i) disable iff (reset_i)
      (result_valid_i && is_above && fault_count_select_i == 2'b00) |=> above_high_flag_o;
   endproperty
   a_above_single: assert property (p_above_single) else $error("Above flag not set");

   property p_below_clear;
      @(posedge clk_i) disable iff (reset_i)
      (result_valid_i && !is_below) |=> !below_low_flag_o;
   endproperty
   a_below_clear: assert property (p_below_clear) else $error("Below flag not cleared");

   // Flags and readback stand until the next measurement
   property p_flag_hold;
      @(posedge clk_i) disable iff (reset_i)
      !result_valid_i |=> $stable(below_low_flag_o) && $stable(above_high_flag_o) &&
         $stable(result_readback_o);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("Flags changed without result");

   property p_mask_mant;
      @(posedge clk_i) disable iff (reset_i)
      (result_valid_i && mask_active) |=>
         result_readback_o[LTL_MANT_MSB:LTL_MANT_LSB] ==
         $past(result_word_i[LTL_MANT_MSB:LTL_MANT_LSB]);
   endproperty
   a_mask_mant: assert property (p_mask_mant) else $error("Masked readback mantissa wrong");

   // Eight results needed: a first one below the limit must not set the flag
   property p_below_wait;
      @(posedge clk_i) disable iff (reset_i)
      (result_valid_i && is_below && fault_count_select_i == 2'b11 && low_cnt_reg == '0) |=>
         !below_low_flag_o;
   endproperty
   a_below_wait: assert property (p_below_wait) else $error("Below flag set too early");

   property p_cnt_sat;
      @(posedge clk_i) disable iff (reset_i)
      (low_cnt_reg <= LTL_FAULT_MAX) && (high_cnt_reg <= LTL_FAULT_MAX);
   endproperty
   a_cnt_sat: assert property (p_cnt_sat) else $error("Fault counter past its limit");
endmodule
`default_nettype wire

// [sim/light_threshold_limit_registers_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fails++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module light_threshold_limit_registers_tb;
   import ltl_pkg::*;
   localparam logic [15:0] MAKER = 16'h6B2D; // Arbitrary value
   localparam logic [15:0] PART = 16'h49C7; // Arbitrary value
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] reg_addr;
   logic reg_wr;
   logic [15:0] reg_wdata;
   logic reg_rd;
   logic [15:0] reg_rdata_o;
   logic result_valid_i = 1'b0;
   logic [15:0] result_word_i = 16'h0000;
   logic exponent_mask_enable_i = 1'b0;
   logic [3:0] range_select_i = 4'hC;
   logic [1:0] fault_count_select_i = 2'h0;
   logic [15:0] result_readback_o;
   logic above_high_flag_o;
   logic below_low_flag_o;
   int fails = 0;
   int num_checks = 0;
   int cnt_lo = 0;
   int cnt_hi = 0;
   logic [31:0] seed = 32'd75;
   logic [15:0] lo = LTL_LOW_RESET;
   logic [15:0] hi = LTL_HIGH_RESET;
   logic [15:0] d;

   ltl_threshold_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART)) ltl_threshold_regs_i (
      .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
      .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata_o),
      .result_valid_i(result_valid_i), .result_word_i(result_word_i),
      .exponent_mask_enable_i(exponent_mask_enable_i), .range_select_i(range_select_i),
      .fault_count_select_i(fault_count_select_i), .result_readback_o(result_readback_o),
      .above_high_flag_o(above_high_flag_o), .below_low_flag_o(below_low_flag_o));

   ltl_host_model ltl_host_model_i (
      .clk_i(clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata),
      .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata_o));

   initial begin
      forever #25 clk_i = ~clk_i;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [26:0] lux(input logic [15:0] w);
      logic [26:0] m;
      m = 27'(w[11:0]);
      return m << w[15:12];
   endfunction

   task automatic complete_run();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic set_limits(input logic [15:0] l, input logic [15:0] h);
      lo = l;
      hi = h;
      ltl_host_model_i.write(LTL_OFS_LOW, l);
      ltl_host_model_i.write(LTL_OFS_HIGH, h);
      ltl_host_model_i.read(LTL_OFS_LOW, d);
      `CHK("low limit", l, d)
      ltl_host_model_i.read(LTL_OFS_HIGH, d);
      `CHK("high limit", h, d)
   endtask

   // One conversion result with its mode inputs, then the flags are compared
   task automatic measure(input logic [15:0] w, input logic [1:0] fc, input logic me,
                          input logic [3:0] rn);
      logic [15:0] erb;
      @(posedge clk_i);
      result_valid_i <= 1'b1;
      result_word_i <= w;
      fault_count_select_i <= fc;
      exponent_mask_enable_i <= me;
      range_select_i <= rn;
      @(posedge clk_i);
      result_valid_i <= 1'b0;
      result_word_i <= ~w;
      cnt_lo = (lux(w) < lux(lo)) ? ((cnt_lo < 8) ? cnt_lo + 1 : 8) : 0;
      cnt_hi = (lux(w) > lux(hi)) ? ((cnt_hi < 8) ? cnt_hi + 1 : 8) : 0;
      erb = (me && rn < LTL_RANGE_AUTO_MIN) ? {LTL_MASKED_EXP, w[11:0]} : w;
      @(posedge clk_i);
      #1;
      `CHK("below flag", 1'(cnt_lo >= (1 << fc)), below_low_flag_o)
      `CHK("above flag", 1'(cnt_hi >= (1 << fc)), above_high_flag_o)
      `CHK("readback", erb, result_readback_o)
   endtask

   initial begin
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      ltl_host_model_i.read(LTL_OFS_LOW, d);
      `CHK("low reset", LTL_LOW_RESET, d)
      ltl_host_model_i.read(LTL_OFS_HIGH, d);
      `CHK("high reset", LTL_HIGH_RESET, d)
      ltl_host_model_i.write(LTL_OFS_MAKER, ~MAKER);
      ltl_host_model_i.write(LTL_OFS_PART, ~PART);
      ltl_host_model_i.write(8'h10, 16'h5A5A);
      ltl_host_model_i.read(LTL_OFS_MAKER, d);
      `CHK("maker code", MAKER, d)
      ltl_host_model_i.read(LTL_OFS_PART, d);
      `CHK("part code", PART, d)
      ltl_host_model_i.read(8'h10, d);
      `CHK("unmapped", LTL_UNMAPPED_READ, d)
      // Full-scale result equal to the reset high limit is not above it
      measure(LTL_HIGH_RESET, 2'h0, 1'b0, 4'hC);
      set_limits(16'h2040, 16'h0FFF);
      for (int f = 0; f < 4; f++) begin
         for (int k = 0; k < 9; k++) begin
            measure(16'h007F, 2'(f), 1'b1, 4'h3);
         end
         measure(16'h0100, 2'(f), 1'b0, 4'h0);
         for (int k = 0; k < 9; k++) begin
            measure(16'h1800, 2'(f), 1'b1, 4'hD);
         end
         measure(16'h0FFF, 2'(f), 1'b0, 4'h0);
      end
      for (int i = 0; i < 200; i++) begin
         if (i % 25 == 0) begin
            d = 16'(rnd());
            // Same manual range in both exponents, as software is advised to do
            set_limits({d[15:12], 12'(rnd())}, {d[15:12], 12'(rnd())});
         end
         d = 16'(rnd());
         measure({lo[15:12], d[11:0]}, 2'(rnd()), d[12], 4'(rnd()));
         measure(16'(rnd()), 2'(rnd()), d[13], 4'(rnd()));
      end
      // Reset in mid-run after a result above the limit has started the high count
      measure(16'hFFFF, 2'h0, 1'b0, 4'hC);
      @(posedge clk_i);
      reset_i <= 1'b1;
      @(posedge clk_i);
      #1;
      `CHK("read data in reset", 16'h0000, reg_rdata_o)
      `CHK("readback in reset", 16'h0000, result_readback_o)
      `CHK("flags in reset", 2'b00, {above_high_flag_o, below_low_flag_o})
      @(posedge clk_i);
      reset_i <= 1'b0;
      lo = LTL_LOW_RESET;
      hi = LTL_HIGH_RESET;
      cnt_lo = 0;
      cnt_hi = 0;
      ltl_host_model_i.read(LTL_OFS_LOW, d);
      `CHK("low reset again", LTL_LOW_RESET, d)
      ltl_host_model_i.read(LTL_OFS_HIGH, d);
      `CHK("high reset again", LTL_HIGH_RESET, d)
      // A cleared high count needs two results again before the flag rises
      measure(16'hFFFF, 2'h1, 1'b0, 4'hC);
      measure(16'hFFFF, 2'h1, 1'b0, 4'hC);
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      complete_run();
   end
endmodule
`default_nettype wire

// [sim/ltl_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ltl_host_model (
   input wire logic clk_i,
   output logic [7:0] reg_addr_o = 8'h00,
   output logic reg_wr_o = 1'b0,
   output logic [15:0] reg_wdata_o = 16'h0000,
   output logic reg_rd_o = 1'b0,
   input wire logic [15:0] reg_rdata_i
);
   // Lines let go after a transfer show the inverse of their last value
   task automatic write(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      reg_wr_o <= 1'b1;
      reg_addr_o <= a;
      reg_wdata_o <= d;
      @(posedge clk_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask

   task automatic read(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_i);
      reg_rd_o <= 1'b1;
      reg_addr_o <= a;
      @(posedge clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      @(posedge clk_i);
      #1;
      d = reg_rdata_i;
   endtask
endmodule
`default_nettype wire
